// ==== design/brr_pkg.sv ====
// package for the bridge result readout block: read map, status layout, data carriers
// assumes one 20 MHz clock and a host reading by 3-bit read address
package brr_pkg;

   // ---------------------------------------------------------------
   // read map
   // ---------------------------------------------------------------
   localparam logic [2:0] ADDR_FIRST_HALF = 3'h0;
   localparam logic [2:0] ADDR_SECOND_HALF = 3'h1;
   localparam logic [2:0] ADDR_STATUS = 3'h2;
   localparam logic [2:0] ADDR_CFG0_MIRROR = 3'h3;
   localparam logic [2:0] ADDR_DISCHARGE = 3'h4;
   localparam logic [2:0] ADDR_CAL_PERIOD = 3'h5;
   localparam logic [2:0] ADDR_COMP_A = 3'h6;
   localparam logic [2:0] ADDR_COMP_B = 3'h7;

   localparam int DATA_W = 24;
   localparam logic [23:0] RESULT_RESET = 24'h000000;

   // ---------------------------------------------------------------
   // status word fields
   // ---------------------------------------------------------------
   localparam int STAT_BRIDGE_NUM = 23;
   localparam int STAT_TEMP_VALID = 22;
   localparam int STAT_SECOND_VALID = 21;
   localparam int STAT_FIRST_VALID = 20;
   localparam int STAT_RAM_COLLIDE = 19;
   localparam int STAT_TEMP_TIMEOUT = 18;
   localparam int STAT_SECOND_TIMEOUT = 17;
   localparam int STAT_FIRST_TIMEOUT = 16;
   localparam int TEMP_W = 16;

   // fixed-point fraction widths (host divides by 256 and 65536)
   localparam int HALF_FRAC_BITS = 8;
   localparam int DISCHARGE_FRAC_BITS = 16;
   localparam int CAL_LSB_GROUP = 8;

   // bridge select codes
   localparam logic [1:0] BRIDGE_BOTH_A = 2'h0;
   localparam logic [1:0] BRIDGE_FIRST = 2'h1;
   localparam logic [1:0] BRIDGE_SECOND = 2'h2;
   localparam logic [1:0] BRIDGE_BOTH_B = 2'h3;

   // output mode of the second slot
   typedef enum logic [1:0] {
      BRR_SLOT_RAW,
      BRR_SLOT_SUM,
      BRR_SLOT_DIFF
   } brr_slot_mode_t;

   // configuration seen by the readout
   typedef struct packed {
      logic [1:0] bridge_select;
      logic sum_output_mode;
      logic difference_output_mode;
      logic double_bridge;
   } brr_cfg_t;

   // one completed measurement from the converter core
   typedef struct packed {
      logic bridge_number;
      logic [23:0] first_half;
      logic [23:0] second_half;
      logic first_timeout;
      logic second_timeout;
   } brr_bridge_result_t;

   // timer and compensation results
   typedef struct packed {
      logic [23:0] discharge_time;
      logic [23:0] calibration_period;
      logic [23:0] comp_a;
      logic [23:0] comp_b;
   } brr_timer_result_t;

endpackage

// ==== design/brr_readout.sv ====
// bridge result readout: eight 24-bit read locations for the host
// assumes synchronous inputs; result strobes are one-cycle pulses from the core
`timescale 1ns/1ps

// Operation
// - halfbridge results are 16.8 unsigned fixed point
// - single bridge: select picks slots, sum/diff
// - double bridge: select fixes bridge, else status
// - status top bit shows last measured fullbridge
// - valid flags for temperature, second, first
// - error flag on converter/arithmetic RAM collision
// - timeout flags per halfbridge and temperature
// - address 3 mirrors write register 0
// - range 2 discharge time is 8.16 fixed
// - range 1 discharge time is integer LSBs
// - address 5 holds calibration period in 8-LSB
// - addresses 6,7 hold switch compensation values
module brr_readout (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire brr_pkg::brr_cfg_t cfg_in,
   input wire logic [23:0] config_zero_in,
   input wire logic bridge_done_in,
   input wire brr_pkg::brr_bridge_result_t bridge_result_in,
   input wire logic temp_done_in,
   input wire logic [15:0] temperature_in,
   input wire logic temp_timeout_in,
   input wire logic ram_collide_in,
   input wire logic timer_done_in,
   input wire brr_pkg::brr_timer_result_t timer_result_in,
   input wire logic [2:0] read_addr_in,
   input wire logic read_strobe_in,
   output logic [23:0] read_data_out,
   output logic read_valid_out
);

   // ---------------------------------------------------------------
   // stored results
   // ---------------------------------------------------------------
   logic [23:0] first_half_result;
   logic [23:0] second_half_result;
   logic measured_bridge_number;
   logic temperature_valid;
   logic second_half_valid;
   logic first_half_valid;
   logic ram_collide_error;
   logic first_half_timeout;
   logic second_half_timeout;
   logic temperature_timeout;
   logic [15:0] temperature_result;
   logic [23:0] discharge_time_result;
   logic [23:0] calibration_period_result;
   logic [23:0] switch_comp_value_a;
   logic [23:0] switch_comp_value_b;
   logic [23:0] config_zero_mirror;

   brr_pkg::brr_slot_mode_t slot_mode;
   logic load_first;
   logic load_second;
   logic [23:0] next_second;
   logic [23:0] status_word;

   // second slot content per mode; arithmetic kept to 24 bits, wraps like the core
   function automatic logic [23:0] slot_value(input brr_pkg::brr_slot_mode_t mode,
                                              input logic [23:0] a,
                                              input logic [23:0] b);
      logic [23:0] r;
      r = b;
      unique case (mode)
         brr_pkg::BRR_SLOT_RAW: r = b;
         brr_pkg::BRR_SLOT_SUM: r = 24'(a + b);
         brr_pkg::BRR_SLOT_DIFF: r = 24'(b - a);
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------------
   // slot selection
   // ---------------------------------------------------------------
   always_comb begin
      slot_mode = brr_pkg::BRR_SLOT_RAW;
      load_first = 1'b0;
      load_second = 1'b0;
      if (cfg_in.bridge_select == brr_pkg::BRIDGE_BOTH_A ||
          cfg_in.bridge_select == brr_pkg::BRIDGE_BOTH_B) begin
         if (cfg_in.sum_output_mode) begin
            slot_mode = brr_pkg::BRR_SLOT_SUM;
         end else if (cfg_in.difference_output_mode) begin
            slot_mode = brr_pkg::BRR_SLOT_DIFF;
         end
      end
      if (bridge_done_in) begin
         if (!cfg_in.double_bridge) begin
            unique case (cfg_in.bridge_select)
               brr_pkg::BRIDGE_FIRST: load_first = 1'b1;
               brr_pkg::BRIDGE_SECOND: load_second = 1'b1;
               default: begin
                  load_first = (slot_mode == brr_pkg::BRR_SLOT_RAW);
                  load_second = 1'b1;
               end
            endcase
         end else begin
            unique case (cfg_in.bridge_select)
               brr_pkg::BRIDGE_FIRST: begin
                  load_first = !bridge_result_in.bridge_number;
                  load_second = !bridge_result_in.bridge_number;
               end
               brr_pkg::BRIDGE_SECOND: begin
                  load_first = bridge_result_in.bridge_number;
                  load_second = bridge_result_in.bridge_number;
               end
               default: begin
                  // first slot only for bridge one in raw mode
                  load_first = (slot_mode == brr_pkg::BRR_SLOT_RAW) &&
                               !bridge_result_in.bridge_number;
                  load_second = 1'b1;
               end
            endcase
         end
      end
      next_second = slot_value(slot_mode, bridge_result_in.first_half,
                               bridge_result_in.second_half);
   end

   // ---------------------------------------------------------------
   // halfbridge results, 16 integer and 8 fractional bits as delivered
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         first_half_result <= brr_pkg::RESULT_RESET;
         second_half_result <= brr_pkg::RESULT_RESET;
         first_half_valid <= 1'b0;
         second_half_valid <= 1'b0;
         first_half_timeout <= 1'b0;
         second_half_timeout <= 1'b0;
      end else begin
         if (load_first) begin
            first_half_result <= bridge_result_in.first_half;
            first_half_timeout <= bridge_result_in.first_timeout;
            first_half_valid <= !bridge_result_in.first_timeout;
         end
         if (load_second) begin
            second_half_result <= next_second;
            second_half_timeout <= bridge_result_in.second_timeout;
            second_half_valid <= !bridge_result_in.second_timeout;
         end
      end
   end

   // ---------------------------------------------------------------
   // bridge number, temperature and error flags
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         measured_bridge_number <= 1'b0;
      end else if (bridge_done_in) begin
         measured_bridge_number <= cfg_in.double_bridge &&
                                   bridge_result_in.bridge_number;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         temperature_result <= 16'h0000;
         temperature_valid <= 1'b0;
         temperature_timeout <= 1'b0;
      end else if (temp_done_in) begin
         temperature_result <= temperature_in;
         temperature_timeout <= temp_timeout_in;
         temperature_valid <= !temp_timeout_in;
      end
   end

   // sticky until the next measurement completes; a collision in that cycle wins
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         ram_collide_error <= 1'b0;
      end else if (ram_collide_in) begin
         ram_collide_error <= 1'b1;
      end else if (bridge_done_in) begin
         ram_collide_error <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // timer, compensation and mirror
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         discharge_time_result <= brr_pkg::RESULT_RESET;
         calibration_period_result <= brr_pkg::RESULT_RESET;
         switch_comp_value_a <= brr_pkg::RESULT_RESET;
         switch_comp_value_b <= brr_pkg::RESULT_RESET;
      end else if (timer_done_in) begin
         // range 2: 8.16 fixed; range 1: integer LSBs, format set by the core
         discharge_time_result <= timer_result_in.discharge_time;
         calibration_period_result <= timer_result_in.calibration_period;
         switch_comp_value_a <= timer_result_in.comp_a;
         switch_comp_value_b <= timer_result_in.comp_b;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         config_zero_mirror <= brr_pkg::RESULT_RESET;
      end else begin
         config_zero_mirror <= config_zero_in;
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   always_comb begin
      status_word = {8'h00, temperature_result};
      status_word[brr_pkg::STAT_BRIDGE_NUM] = measured_bridge_number;
      status_word[brr_pkg::STAT_TEMP_VALID] = temperature_valid;
      status_word[brr_pkg::STAT_SECOND_VALID] = second_half_valid;
      status_word[brr_pkg::STAT_FIRST_VALID] = first_half_valid;
      status_word[brr_pkg::STAT_RAM_COLLIDE] = ram_collide_error;
      status_word[brr_pkg::STAT_TEMP_TIMEOUT] = temperature_timeout;
      status_word[brr_pkg::STAT_SECOND_TIMEOUT] = second_half_timeout;
      status_word[brr_pkg::STAT_FIRST_TIMEOUT] = first_half_timeout;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         read_data_out <= brr_pkg::RESULT_RESET;
         read_valid_out <= 1'b0;
      end else begin
         read_valid_out <= read_strobe_in;
         if (read_strobe_in) begin
            unique case (read_addr_in)
               brr_pkg::ADDR_FIRST_HALF: read_data_out <= first_half_result;
               brr_pkg::ADDR_SECOND_HALF: read_data_out <= second_half_result;
               brr_pkg::ADDR_STATUS: read_data_out <= status_word;
               brr_pkg::ADDR_CFG0_MIRROR: read_data_out <= config_zero_mirror;
               brr_pkg::ADDR_DISCHARGE: read_data_out <= discharge_time_result;
               brr_pkg::ADDR_CAL_PERIOD: read_data_out <= calibration_period_result;
               brr_pkg::ADDR_COMP_A: read_data_out <= switch_comp_value_a;
               brr_pkg::ADDR_COMP_B: read_data_out <= switch_comp_value_b;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   a_mirror_readback: assert property (
      read_strobe_in && read_addr_in == brr_pkg::ADDR_CFG0_MIRROR && !$past(reset_in)
      |=> read_data_out == $past(config_zero_in, 2))
      else $error("mirror read differs from write register 0");

   a_first_only_load: assert property (
      bridge_done_in && !cfg_in.double_bridge &&
      cfg_in.bridge_select == brr_pkg::BRIDGE_FIRST
      |=> $stable(second_half_result) &&
          first_half_result == $past(bridge_result_in.first_half))
      else $error("select 1 must load only the first slot");

   a_second_only_load: assert property (
      bridge_done_in && !cfg_in.double_bridge &&
      cfg_in.bridge_select == brr_pkg::BRIDGE_SECOND
      |=> $stable(first_half_result))
      else $error("select 2 must not load the first slot");

   a_sum_slot: assert property (
      bridge_done_in && !cfg_in.double_bridge && cfg_in.sum_output_mode &&
      (cfg_in.bridge_select == brr_pkg::BRIDGE_BOTH_A)
      |=> second_half_result == 24'($past(bridge_result_in.first_half) +
                                    $past(bridge_result_in.second_half)))
      else $error("sum mode second slot wrong");

   a_diff_slot: assert property (
      bridge_done_in && !cfg_in.sum_output_mode && cfg_in.difference_output_mode &&
      (cfg_in.bridge_select == brr_pkg::BRIDGE_BOTH_B)
      |=> second_half_result == 24'($past(bridge_result_in.second_half) -
                                    $past(bridge_result_in.first_half)))
      else $error("difference mode second slot wrong");

   a_fixed_bridge: assert property (
      bridge_done_in && cfg_in.double_bridge &&
      cfg_in.bridge_select == brr_pkg::BRIDGE_FIRST && bridge_result_in.bridge_number
      |=> $stable(first_half_result) && $stable(second_half_result))
      else $error("fixed fullbridge one took bridge two data");

   a_bridge_status: assert property (
      bridge_done_in ##1 (!bridge_done_in) [*3] ##0
      (read_strobe_in && read_addr_in == brr_pkg::ADDR_STATUS)
      |=> read_data_out[brr_pkg::STAT_BRIDGE_NUM] ==
          $past(cfg_in.double_bridge && bridge_result_in.bridge_number, 4))
      else $error("status bridge bit not shown");

   a_collide_sticky: assert property (
      ram_collide_in |=> ram_collide_error [*1] ##1
      (ram_collide_error || $past(bridge_done_in)))
      else $error("collision flag lost");

   a_timeout_flags: assert property (
      temp_done_in |=> temperature_timeout == $past(temp_timeout_in) &&
                        temperature_valid == !$past(temp_timeout_in))
      else $error("temperature timeout or valid flag wrong");

   a_read_answer: assert property (
      read_strobe_in && read_addr_in == brr_pkg::ADDR_COMP_B
      |=> read_valid_out && read_data_out == $past(switch_comp_value_b))
      else $error("compensation value b read wrong");

   a_first_valid_flag: assert property (
      bridge_done_in && !cfg_in.double_bridge && !cfg_in.sum_output_mode &&
      !cfg_in.difference_output_mode && cfg_in.bridge_select != brr_pkg::BRIDGE_SECOND
      |=> first_half_valid == !$past(bridge_result_in.first_timeout) &&
          first_half_timeout == $past(bridge_result_in.first_timeout))
      else $error("first halfbridge valid or timeout flag wrong");

   a_second_valid_flag: assert property (
      bridge_done_in && !cfg_in.double_bridge && cfg_in.bridge_select != brr_pkg::BRIDGE_FIRST
      |=> second_half_valid == !$past(bridge_result_in.second_timeout) &&
          second_half_timeout == $past(bridge_result_in.second_timeout))
      else $error("second halfbridge valid or timeout flag wrong");

   a_timer_load: assert property (
      timer_done_in
      |=> discharge_time_result == $past(timer_result_in.discharge_time) &&
          calibration_period_result == $past(timer_result_in.calibration_period) &&
          switch_comp_value_a == $past(timer_result_in.comp_a))
      else $error("timer or compensation result not stored");

   a_collide_set: assert property (
      ram_collide_in && bridge_done_in |=> ram_collide_error)
      else $error("collision lost to a completing measurement");

   c_sum_mode: cover property (bridge_done_in && cfg_in.sum_output_mode);
   c_double_second: cover property (bridge_done_in && cfg_in.double_bridge &&
                                    bridge_result_in.bridge_number);
   c_collision: cover property (ram_collide_in ##1 bridge_done_in);
   c_status_read: cover property (read_strobe_in && read_addr_in == brr_pkg::ADDR_STATUS);
   c_diff_select3: cover property (bridge_done_in && cfg_in.difference_output_mode &&
                                   cfg_in.bridge_select == brr_pkg::BRIDGE_BOTH_B);

endmodule

// ==== test/brr_host_model.sv ====
// host-side read model: turns a bench request into a one-cycle read strobe
// assumes the bench raises req_in for one cycle per read
`timescale 1ns/1ps
module brr_host_model (
   input wire logic clk_in,
   input wire logic req_in,
   input wire logic [2:0] addr_in,
   output logic [2:0] read_addr_out,
   output logic read_strobe_out
);
   initial begin
      read_addr_out = 3'h0;
      read_strobe_out = 1'b0;
   end
   // address toggles between reads so a stale address never looks valid
   always @(posedge clk_in) begin
      read_strobe_out <= req_in;
      read_addr_out <= req_in ? addr_in : ~read_addr_out;
   end
endmodule

// ==== test/tb_top.sv ====
// testbench for the bridge result readout
// assumes the 20 MHz clock and the one-cycle read answer of the block
`timescale 1ns/1ps
module tb_top;
   logic clk_in, reset_in, bdone, tdone, ttmo, coll, tmdone, req, rstb, rvalid;
   brr_pkg::brr_cfg_t cfg;
   brr_pkg::brr_bridge_result_t bres;
   brr_pkg::brr_timer_result_t tres;
   logic [23:0] cfg0, rdata;
   logic [15:0] temp;
   logic [2:0] raddr, haddr;
   int errors, checks_done;

   brr_readout dut (
      .clk_in(clk_in), .reset_in(reset_in), .cfg_in(cfg), .config_zero_in(cfg0),
      .bridge_done_in(bdone), .bridge_result_in(bres), .temp_done_in(tdone),
      .temperature_in(temp), .temp_timeout_in(ttmo), .ram_collide_in(coll),
      .timer_done_in(tmdone), .timer_result_in(tres), .read_addr_in(raddr),
      .read_strobe_in(rstb), .read_data_out(rdata), .read_valid_out(rvalid));
   brr_host_model host (
      .clk_in(clk_in), .req_in(req), .addr_in(haddr),
      .read_addr_out(raddr), .read_strobe_out(rstb));

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rd_chk(input string name, input logic [2:0] a, input logic [23:0] exp,
         input logic [23:0] mask);
      int n;
      @(posedge clk_in);
      req <= 1'b1;
      haddr <= a;
      @(posedge clk_in);
      req <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (rvalid !== 1'b1 && n < 8);
      if (n >= 8) begin
         errors++;
         $display("[FAIL] %s expected valid seen none", name);
         final_report();
      end
      check(name, exp & mask, rdata & mask);
   endtask

   // c = {select, sum, diff, double}; tmo = {first, second}
   task automatic bridge(input logic [4:0] c, input logic bn, input logic [23:0] a,
         input logic [23:0] b, input logic [1:0] tmo);
      @(posedge clk_in);
      cfg <= c;
      bres <= {bn, a, b, tmo};
      bdone <= 1'b1;
      @(posedge clk_in);
      bdone <= 1'b0;
   endtask

   task automatic tpulse(input logic tmo, input logic [15:0] v);
      @(posedge clk_in);
      temp <= v;
      ttmo <= tmo;
      tdone <= 1'b1;
      @(posedge clk_in);
      tdone <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // host adjustment choice: 17 by default, 45 only above rate 20, 29 there on a low core supply
   function automatic logic [5:0] front_end_adjust(input int averaging_rate, input logic low_core);
      logic [5:0] v;
      v = 6'h11;
      if (averaging_rate > 20) begin
         v = low_core ? 6'h1D : 6'h2D;
      end
      return v;
   endfunction

   task automatic t_mirror;
      @(posedge clk_in);
      cfg0 <= 24'hA5C3F0;
      rd_chk("mirror", 3'h3, 24'hA5C3F0, 24'hFFFFFF);
      @(posedge clk_in);
      cfg0 <= 24'h5A3C0F;
      rd_chk("mirror", 3'h3, 24'h5A3C0F, 24'hFFFFFF);
      // adjust-style word: adjust in bits 21:16, calibration adjust 63 in bits 14:8
      @(posedge clk_in);
      cfg0 <= {2'h0, front_end_adjust(25, 1'b0), 1'b0, 7'h3F, 8'h00};
      rd_chk("mirror", 3'h3, 24'h2D3F00, 24'hFFFFFF);
      @(posedge clk_in);
      cfg0 <= {2'h0, front_end_adjust(25, 1'b1), 1'b0, 7'h3F, 8'h00};
      rd_chk("mirror", 3'h3, 24'h1D3F00, 24'hFFFFFF);
      @(posedge clk_in);
      cfg0 <= {2'h0, front_end_adjust(20, 1'b0), 1'b0, 7'h3F, 8'h00};
      rd_chk("mirror", 3'h3, 24'h113F00, 24'hFFFFFF);
      $display("test mirror done");
   endtask

   task automatic t_select;
      logic [23:0] a, b, ea, eb;
      ea = 24'h0;
      eb = 24'h0;
      for (int i = 0; i < 4; i++) begin
         a = 24'(24'h010203 * (i + 1));
         b = 24'(24'h0A0B0C * (i + 1));
         bridge({i[1:0], 3'h0}, 1'b0, a, b, 2'h0);
         if (i != 2) ea = a;
         if (i != 1) eb = b;
         rd_chk("first", 3'h0, ea, 24'hFFFFFF);
         rd_chk("second", 3'h1, eb, 24'hFFFFFF);
      end
      $display("test select done");
   endtask

   task automatic t_sumdiff;
      bridge(5'h00, 1'b0, 24'h000111, 24'h000222, 2'h0);
      bridge(5'h04, 1'b0, 24'h000100, 24'h000280, 2'h0);
      rd_chk("second", 3'h1, 24'h000380, 24'hFFFFFF);
      rd_chk("first", 3'h0, 24'h000111, 24'hFFFFFF);
      bridge(5'h02, 1'b0, 24'h000180, 24'h000500, 2'h0);
      rd_chk("second", 3'h1, 24'h000380, 24'hFFFFFF);
      bridge(5'h1A, 1'b0, 24'h000200, 24'h000A00, 2'h0);
      rd_chk("second", 3'h1, 24'h000800, 24'hFFFFFF);
      bridge(5'h1E, 1'b0, 24'h001000, 24'h000234, 2'h0);
      rd_chk("second", 3'h1, 24'h001234, 24'hFFFFFF);
      $display("test sumdiff done");
   endtask

   task automatic t_double;
      bridge(5'h01, 1'b0, 24'h0A0001, 24'h0A0002, 2'h0);
      rd_chk("first", 3'h0, 24'h0A0001, 24'hFFFFFF);
      rd_chk("bridge bit", 3'h2, 24'h000000, 24'h800000);
      bridge(5'h01, 1'b1, 24'h0B0001, 24'h0B0002, 2'h0);
      rd_chk("second", 3'h1, 24'h0B0002, 24'hFFFFFF);
      rd_chk("first", 3'h0, 24'h0A0001, 24'hFFFFFF);
      rd_chk("bridge bit", 3'h2, 24'h800000, 24'h800000);
      bridge(5'h05, 1'b1, 24'h000010, 24'h000020, 2'h0);
      rd_chk("second", 3'h1, 24'h000030, 24'hFFFFFF);
      bridge(5'h11, 1'b1, 24'h0C0001, 24'h0C0002, 2'h0);
      rd_chk("first", 3'h0, 24'h0C0001, 24'hFFFFFF);
      rd_chk("second", 3'h1, 24'h0C0002, 24'hFFFFFF);
      bridge(5'h09, 1'b0, 24'h0D0001, 24'h0D0002, 2'h0);
      rd_chk("first", 3'h0, 24'h0D0001, 24'hFFFFFF);
      bridge(5'h09, 1'b1, 24'h0E0001, 24'h0E0002, 2'h0);
      rd_chk("bridge bit", 3'h2, 24'h800000, 24'h800000);
      rd_chk("first", 3'h0, 24'h0D0001, 24'hFFFFFF);
      rd_chk("second", 3'h1, 24'h0D0002, 24'hFFFFFF);
      $display("test double done");
   endtask

   task automatic t_flags;
      bridge(5'h00, 1'b0, 24'h000001, 24'h000002, 2'h2);
      rd_chk("status", 3'h2, 24'h210000, 24'hFF0000);
      @(posedge clk_in);
      coll <= 1'b1;
      @(posedge clk_in);
      coll <= 1'b0;
      rd_chk("status", 3'h2, 24'h290000, 24'hFF0000);
      tpulse(1'b1, 16'hBEEF);
      rd_chk("status", 3'h2, 24'h2D0000, 24'hFF0000);
      tpulse(1'b0, 16'h1234);
      rd_chk("status", 3'h2, 24'h691234, 24'hFFFFFF);
      bridge(5'h00, 1'b0, 24'h000001, 24'h000002, 2'h0);
      rd_chk("status", 3'h2, 24'h701234, 24'hFFFFFF);
      bridge(5'h00, 1'b0, 24'h000001, 24'h000002, 2'h1);
      rd_chk("status", 3'h2, 24'h521234, 24'hFFFFFF);
      // collision in the same cycle as a completing measurement: the error stays set
      @(posedge clk_in);
      coll <= 1'b1;
      bdone <= 1'b1;
      @(posedge clk_in);
      coll <= 1'b0;
      bdone <= 1'b0;
      rd_chk("status", 3'h2, 24'h5A1234, 24'hFFFFFF);
      $display("test flags done");
   endtask

   task automatic t_timer;
      logic [23:0] v [4];
      v = '{24'h123456, 24'h00ABCD, 24'h765432, 24'h0F0E0D};
      @(posedge clk_in);
      tres <= {v[0], v[1], v[2], v[3]};
      tmdone <= 1'b1;
      @(posedge clk_in);
      tmdone <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd_chk("timer", 3'(i + 4), v[i], 24'hFFFFFF);
      end
      $display("test timer done");
   endtask

   initial begin
      errors = 0;
      checks_done = 0;
      reset_in = 1'b1;
      cfg = '0;
      bres = '0;
      tres = '0;
      {bdone, tdone, ttmo, coll, tmdone, req} = 6'h00;
      cfg0 = 24'h0;
      temp = 16'h0;
      haddr = 3'h0;
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      rd_chk("reset status", 3'h2, 24'h000000, 24'hFFFFFF);
      rd_chk("reset first", 3'h0, 24'h000000, 24'hFFFFFF);
      $display("test reset done");
      t_mirror();
      t_select();
      t_sumdiff();
      t_double();
      t_flags();
      t_timer();
      final_report();
   end
endmodule
